// ### hdl/smpr_defs.svh
// Register offsets, field positions and reset values
`ifndef SMPR_DEFS_SVH
`define SMPR_DEFS_SVH
`define SMPR_IDX_DWELL_LO   10'h24b
`define SMPR_IDX_DWELL_HI   10'h24c
`define SMPR_IDX_SYNC_CTL   10'h26f
`define SMPR_IDX_MON_CTL    10'h270
`define SMPR_IDX_PERIOD0    10'h271
`define SMPR_IDX_PERIOD1    10'h272
`define SMPR_IDX_PERIOD2    10'h273
`define SMPR_IDX_RES_CTL    10'h274
`define SMPR_IDX_RESULT0    10'h275
`define SMPR_IDX_RESULT1    10'h276
`define SMPR_IDX_RESULT2    10'h277
`define SMPR_IDX_PCOUNT     10'h278
`define SMPR_IDX_SIDEBAND   10'h279
`define SMPR_BIT_PEAK_EN    1
`define SMPR_BIT_RES_SEL    0
`define SMPR_BIT_RES_UPD    4
`define SMPR_RST_PERIOD     24'h000080
`define SMPR_RST_RES_CTL    8'h01
`define SMPR_RST_ZERO8      8'h00
`endif

// ### hdl/smpr_monitor.sv
// Signal monitor register block with peak readout on classic Wishbone
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "smpr_defs.svh"
module smpr_monitor #(
  parameter int SAMPLE_W = 14
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [11:0]          wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Decimated sample stream and chip sync
  input  wire logic                 sampleValid,
  input  wire logic [SAMPLE_W-1:0]  sampleData,
  input  wire logic                 syncPin,
  // Configuration towards neighbouring logic
  output logic      [15:0]          thresholdAlarmDwell,
  output logic      [1:0]           sidebandPortCtl
);
  import smpr_pkg::*;

  logic [7:0]  dwellLo_q;
  logic [7:0]  dwellHi_q;
  logic [1:0]  syncMode_q;
  logic        peakEn_q;
  logic [23:0] period_q;
  logic        resSel_q;
  logic        resUpd_q;
  logic [19:0] result_q;
  logic [7:0]  pcount_q;
  logic [1:0]  sideband_q;
  logic        syncMeta_q;
  logic        syncSync_q;
  logic        syncPrev_q;
  logic        syncEdge;
  logic        restart;
  logic        armed_q;
  logic [12:0] peakHold;
  logic [23:0] countHold;
  logic        req;
  logic        wr;
  logic        wrByte;
  logic [9:0]  idx;
  logic [7:0]  wByte;
  logic [7:0]  rByte;
  logic        mapped;

  // Reset image of the result control byte, so its select bit is taken by index
  localparam logic [7:0] RES_CTL_RST = `SMPR_RST_RES_CTL;

  // Word addressing: register index times four
  assign idx    = wb_adr_i[11:2];
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr     = req && wb_we_i;
  assign wrByte = wr && wb_sel_i[0];
  assign wByte  = wb_dat_i[7:0];

  // Ack one cycle after the request; dropped the cycle after
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Dwell time bytes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dwellLo_q <= `SMPR_RST_ZERO8;
      dwellHi_q <= `SMPR_RST_ZERO8;
    end else if (wrByte && idx == `SMPR_IDX_DWELL_LO) begin
      dwellLo_q <= wByte;
    end else if (wrByte && idx == `SMPR_IDX_DWELL_HI) begin
      dwellHi_q <= wByte;
    end
  end
  assign thresholdAlarmDwell = {dwellHi_q, dwellLo_q};

  // Sync mode, peak enable and sideband control
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      syncMode_q <= 2'h0;
      peakEn_q   <= 1'b0;
      sideband_q <= 2'h0;
    end else if (wrByte) begin
      if (idx == `SMPR_IDX_SYNC_CTL) begin
        syncMode_q <= wByte[1:0];
      end
      if (idx == `SMPR_IDX_MON_CTL) begin
        peakEn_q <= wByte[`SMPR_BIT_PEAK_EN];
      end
      if (idx == `SMPR_IDX_SIDEBAND) begin
        sideband_q <= wByte[1:0];
      end
    end
  end
  assign sidebandPortCtl = sideband_q;

  // Period bytes; bit 0 of the low byte is fixed at zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      period_q <= `SMPR_RST_PERIOD;
    end else if (wrByte) begin
      if (idx == `SMPR_IDX_PERIOD0) begin
        period_q[7:0] <= {wByte[7:1], 1'b0};
      end
      if (idx == `SMPR_IDX_PERIOD1) begin
        period_q[15:8] <= wByte;
      end
      if (idx == `SMPR_IDX_PERIOD2) begin
        period_q[23:16] <= wByte;
      end
    end
  end

  // Sync pin crosses two flops before the edge detector looks at it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      syncMeta_q <= 1'b0;
      syncSync_q <= 1'b0;
      syncPrev_q <= 1'b0;
    end else begin
      syncMeta_q <= syncPin;
      syncSync_q <= syncMeta_q;
      syncPrev_q <= syncSync_q;
    end
  end
  assign syncEdge = syncSync_q && !syncPrev_q;

  // One-shot arming: cleared after the first sync edge in that mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (wrByte && idx == `SMPR_IDX_SYNC_CTL) begin
      armed_q <= (smpr_sync_t'(wByte[1:0]) == SMPR_SYNC_ONCE);
    end else if (syncEdge) begin
      armed_q <= 1'b0;
    end
  end

  // Realign the period on sync: every edge, one edge, or never
  always_comb begin
    case (smpr_sync_t'(syncMode_q))
      SMPR_SYNC_CONT: restart = syncEdge;
      SMPR_SYNC_ONCE: restart = syncEdge && armed_q;
      default:        restart = 1'b0;
    endcase
  end

  // Peak detector runs only while enabled
  smpr_peak_detect #(
    .SAMPLE_W (SAMPLE_W),
    .MAG_W    (13)
  ) u_peak (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .enable      (peakEn_q),
    .period      (period_q),
    .restart     (restart),
    .sampleValid (sampleValid),
    .sampleData  (sampleData),
    .peakHold    (peakHold),
    .countHold   (countHold)
  );

  // Result selection and self-clearing update bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resSel_q <= RES_CTL_RST[`SMPR_BIT_RES_SEL];
      resUpd_q <= 1'b0;
    end else if (wrByte && idx == `SMPR_IDX_RES_CTL) begin
      resSel_q <= wByte[`SMPR_BIT_RES_SEL];
      resUpd_q <= wByte[`SMPR_BIT_RES_UPD];
    end else begin
      resUpd_q <= 1'b0;
    end
  end

  // Readable results change only on an update request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_q <= 20'h00000;
      pcount_q <= 8'h00;
    end else if (resUpd_q) begin
      result_q <= resSel_q ? {peakHold, 7'h00} : 20'h00000;
      pcount_q <= countHold[7:0];
    end
  end

  // Read data selection; unmapped indices read zero
  always_comb begin
    rByte  = 8'h00;
    mapped = 1'b1;
    case (idx)
      `SMPR_IDX_DWELL_LO: rByte = dwellLo_q;
      `SMPR_IDX_DWELL_HI: rByte = dwellHi_q;
      `SMPR_IDX_SYNC_CTL: rByte = {6'h00, syncMode_q};
      `SMPR_IDX_MON_CTL:  rByte = {6'h00, peakEn_q, 1'b0};
      `SMPR_IDX_PERIOD0:  rByte = period_q[7:0];
      `SMPR_IDX_PERIOD1:  rByte = period_q[15:8];
      `SMPR_IDX_PERIOD2:  rByte = period_q[23:16];
      `SMPR_IDX_RES_CTL:  rByte = {3'h0, resUpd_q, 3'h0, resSel_q};
      `SMPR_IDX_RESULT0:  rByte = result_q[7:0];
      `SMPR_IDX_RESULT1:  rByte = result_q[15:8];
      `SMPR_IDX_RESULT2:  rByte = {4'h0, result_q[19:16]};
      `SMPR_IDX_PCOUNT:   rByte = pcount_q;
      `SMPR_IDX_SIDEBAND: rByte = {6'h00, sideband_q};
      default:            mapped = 1'b0;
    endcase
  end

  // Registered read data, presented with ack
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= mapped ? {24'h000000, rByte} : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ### hdl/smpr_peak_detect.sv
// Peak magnitude detector over a programmable period of output samples
`timescale 1ns/1ps
`default_nettype none
module smpr_peak_detect #(
  parameter int SAMPLE_W = 14,
  parameter int MAG_W    = 13
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Control
  input  wire logic                enable,
  input  wire logic [23:0]         period,
  input  wire logic                restart,
  // Samples
  input  wire logic                sampleValid,
  input  wire logic [SAMPLE_W-1:0] sampleData,
  // Results of the last completed period
  output logic      [MAG_W-1:0]    peakHold,
  output logic      [23:0]         countHold
);
  logic [MAG_W-1:0] peak_q;
  logic [23:0]      count_q;
  logic [MAG_W-1:0] mag;
  logic             last;

  // Magnitude of a two's complement sample, saturated to MAG_W bits
  always_comb begin
    logic [SAMPLE_W-1:0] absVal;
    absVal = sampleData[SAMPLE_W-1] ? (~sampleData + 1'b1) : sampleData;
    if (absVal[SAMPLE_W-1]) begin
      mag = '1;
    end else begin
      mag = absVal[MAG_W-1:0];
    end
  end

  assign last = (count_q + 24'h000001 >= period);

  // Running peak and sample count; a period of zero behaves like one
  always_ff @(posedge clk_sys) begin
    if (rst || restart || !enable) begin
      peak_q  <= '0;
      count_q <= '0;
    end else if (sampleValid) begin
      if (last) begin
        peak_q  <= '0;
        count_q <= '0;
      end else begin
        peak_q  <= (mag > peak_q) ? mag : peak_q;
        count_q <= count_q + 24'h000001;
      end
    end
  end

  // Hold the finished period so software sees a stable value
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      peakHold  <= '0;
      countHold <= '0;
    end else if (enable && sampleValid && last && !restart) begin
      peakHold  <= (mag > peak_q) ? mag : peak_q;
      countHold <= count_q + 24'h000001;
    end
  end
endmodule
`default_nettype wire

// ### hdl/smpr_pkg.sv
// Types shared by the signal monitor files
package smpr_pkg;
  typedef enum logic [1:0] {
    SMPR_SYNC_OFF,
    SMPR_SYNC_CONT,
    SMPR_SYNC_ONCE,
    SMPR_SYNC_RSVD
  } smpr_sync_t;
endpackage

// ### tb/smpr_monitor_bench.sv
// Self-checking bench for the signal monitor register block
`timescale 1ns/1ps
`default_nettype none
module smpr_monitor_bench;
  // Stimulus and observed outputs
  logic        clk_sys = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        syncPin = 1'b0, sampleValid = 1'b0, wb_ack_o;
  logic [13:0] sampleData = 14'h0000, peakVal = 14'h305f; // Sample of magnitude 4001
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'h0, slot = 4'h0;
  logic [31:0] datW = 32'h0, wb_dat_o;
  logic [15:0] thresholdAlarmDwell;
  logic [1:0]  sidebandPortCtl;
  logic [7:0]  rd;
  int          error_cnt = 0, checks_done = 0, cycles = 0;
  // Writable registers and their reset values; byte address is four times the index
  logic [11:0] rAdr [9] = '{12'h92c, 12'h930, 12'h9bc, 12'h9c0, 12'h9c4, 12'h9c8, 12'h9cc,
                            12'h9d0, 12'h9e4};
  logic [7:0]  rRst [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h00};
  always #10 clk_sys = ~clk_sys;
  smpr_monitor u_dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sampleValid(sampleValid), .sampleData(sampleData),
    .syncPin(syncPin), .thresholdAlarmDwell(thresholdAlarmDwell),
    .sidebandPortCtl(sidebandPortCtl));
  // One sample a cycle; the test value once in sixteen, so every period holds it
  always @(posedge clk_sys) begin
    slot <= slot + 4'h1;
    sampleValid <= 1'b1;
    sampleData <= (slot == 4'h3) ? peakVal : 14'h0002;
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Classic single cycle; waits for ack, the timeout bounds a hang
  task automatic wbDo(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= {24'h0, d};
    sel <= s;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rdChk(input string nm, input logic [11:0] a, input logic [7:0] e);
    wbDo(1'b0, a, 8'h00, 4'h1);
    check(nm, {8'h0, rd}, {8'h0, e});
  endtask
  task automatic resChk(input logic [7:0] b0, b1, b2);
    rdChk("result 0", 12'h9d4, b0);
    rdChk("result 1", 12'h9d8, b1);
    rdChk("result 2", 12'h9dc, b2);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rdChk("reset value", rAdr[i], rRst[i]);
    end
    rdChk("unmapped", 12'h000, 8'h00);
    // Dwell bytes form the 16-bit output; a write with lane 0 off is dropped
    wbDo(1'b1, 12'h92c, 8'ha5, 4'h1);
    wbDo(1'b1, 12'h930, 8'h3c, 4'h1);
    wbDo(1'b1, 12'h92c, 8'hff, 4'he);
    check("dwell", thresholdAlarmDwell, 16'h3ca5);
    // Sideband control bits reach their output port
    wbDo(1'b1, 12'h9e4, 8'h03, 4'h1);
    check("sideband", {14'h0, sidebandPortCtl}, 16'h0003);
    for (int m = 2; m >= 0; m--) begin
      wbDo(1'b1, 12'h9bc, 8'(m), 4'h1);
      rdChk("sync mode", 12'h9bc, 8'(m));
    end
    syncPin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    syncPin <= 1'b0;
    // Sixteen-cycle period, low bit of the period reads zero
    wbDo(1'b1, 12'h9c4, 8'h11, 4'h1);
    rdChk("period low", 12'h9c4, 8'h10);
    wbDo(1'b1, 12'h9c0, 8'h02, 4'h1);
    repeat (60) @(posedge clk_sys);
    wbDo(1'b1, 12'h9d0, 8'h11, 4'h1);
    rdChk("update clears", 12'h9d0, 8'h01);
    resChk(8'h80, 8'hd0, 8'h07);
    rdChk("period count", 12'h9e0, 8'h10);
    // Smaller peak must stay hidden until the next update
    peakVal <= 14'h0007;
    repeat (60) @(posedge clk_sys);
    resChk(8'h80, 8'hd0, 8'h07);
    wbDo(1'b1, 12'h9d0, 8'h11, 4'h1);
    resChk(8'h80, 8'h03, 8'h00);
    wbDo(1'b1, 12'h9d0, 8'h10, 4'h1);
    resChk(8'h00, 8'h00, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire

// ### tb/smpr_monitor_sva.sv
// Port-level assertions for the signal monitor register block
`timescale 1ns/1ps
`default_nettype none
module smpr_monitor_sva (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Configuration outputs
  input wire logic [15:0] thresholdAlarmDwell,
  input wire logic [1:0]  sidebandPortCtl
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A request still waiting for its ack, and dwell byte writes among them
  wire req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wrLo = req && wb_we_i && wb_sel_i[0] && wb_adr_i == 12'h92c;
  wire wrHi = req && wb_we_i && wb_sel_i[0] && wb_adr_i == 12'h930;
  a_ack_next: assert property (req |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(req)) else $error("ack unasked");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read lanes set");
  a_dwell_low: assert property (wrLo |=> ##1 thresholdAlarmDwell[7:0] == $past(wb_dat_i[7:0], 2))
    else $error("dwell low not written");
  a_dwell_high: assert property (wrHi |=> ##1 thresholdAlarmDwell[15:8] == $past(wb_dat_i[7:0], 2))
    else $error("dwell high not written");
  a_dwell_hold: assert property (!(wb_cyc_i && wb_stb_i && wb_we_i) |=> $stable(thresholdAlarmDwell))
    else $error("dwell changed without write");
  a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i == 12'h000 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_reset_clear: assert property (disable iff (1'b0) rst |=> thresholdAlarmDwell == 16'h0
    && sidebandPortCtl == 2'h0 && !wb_ack_o) else $error("reset values wrong");
endmodule
bind smpr_monitor smpr_monitor_sva u_sva (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .thresholdAlarmDwell(thresholdAlarmDwell), .sidebandPortCtl(sidebandPortCtl));
`default_nettype wire
